// ===== logic/sd_irq_pkg.sv
// constants and types shared by the sd host interrupt and masking block
// Overview of operation
// - primary mask: response end b0, access end b2, card-detect removal b3, insertion b4
// - primary mask: dat3 removal b8 and dat3 insertion b9, for presence via dat3
// - primary mask b1, b7-b5, b31-b10 read as zero and ignore writes
// - secondary mask b0-b6: command, crc, end bit, timeout, illegal write/read, response timeout
// - secondary mask: buffer read ready b8, buffer write ready b9, illegal access b15
// - secondary mask b7, b14-b10, b31-b16 read as zero and ignore writes
// - four separate request lines: buffer access, card detect, card access, sdio access
// - event reaches processor only if mask permits and controller enable is set
// - buffer access request can trigger the transfer controller; its end raises interrupt
// - sdio request asserts on sdio events; cause readable in separate sdio status
// - card access and detect requests follow protocol status; causes in two registers
// - writable flags clear on write of one; zero keeps; read-only flags ignore writes
package sd_irq_pkg;
   // register byte addresses
   localparam logic [7:0] OFS_STATUS_PRI = 8'h00;
   localparam logic [7:0] OFS_STATUS_SEC = 8'h04;
   localparam logic [7:0] OFS_MASK_PRI   = 8'h08;
   localparam logic [7:0] OFS_MASK_SEC   = 8'h0c;
   localparam logic [7:0] OFS_SDIO_STAT  = 8'h10;
   localparam logic [7:0] OFS_SDIO_MASK  = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT   = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c;
   // primary field positions
   localparam int BIT_RESP_END   = 0;
   localparam int BIT_ACC_END    = 2;
   localparam int BIT_CD_REMOVE  = 3;
   localparam int BIT_CD_INSERT  = 4;
   localparam int BIT_CD_MON     = 5;
   localparam int BIT_WP_MON     = 7;
   localparam int BIT_D3_REMOVE  = 8;
   localparam int BIT_D3_INSERT  = 9;
   localparam int BIT_D3_MON     = 10;
   // secondary field positions (b0-b6 errors in order, then monitors, buffer events and illegal access)
   localparam int BIT_D0_MON     = 7;
   localparam int BIT_BUF_RD     = 8;
   localparam int BIT_BUF_WR     = 9;
   localparam int BIT_CMD_BUSY   = 14;
   localparam int BIT_ILL_ACCESS = 15;
   // sdio field positions
   localparam int BIT_SDIO_IRQ   = 0;
   localparam int BIT_SDIO_EXPUB = 14;
   localparam int BIT_SDIO_EXWT  = 15;
   // writable bit maps of each register, then the request line groups
   localparam logic [31:0] WR_PRI       = 32'h0000_031d;
   localparam logic [31:0] WR_SEC       = 32'h0000_837f;
   localparam logic [31:0] WR_SDIO      = 32'h0000_c001;
   localparam logic [31:0] DET_PRI      = 32'h0000_0318;
   localparam logic [31:0] ACC_PRI      = 32'h0000_0005;
   localparam logic [31:0] BUF_SEC      = 32'h0000_0300;
   localparam logic [31:0] ACC_SEC      = 32'h0000_807f;
   localparam logic [4:0]  WR_IRQ       = 5'h1f;
   // reset values
   localparam logic [31:0] RST_MASK     = 32'h0000_0000;
   localparam logic [4:0]  RST_IRQ_MASK = 5'h00;
   localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
   // interrupt status positions
   localparam int IRQ_BUF  = 0;
   localparam int IRQ_DET  = 1;
   localparam int IRQ_ACC  = 2;
   localparam int IRQ_SDIO = 3;
   localparam int IRQ_XFER = 4;

   // one-cycle event pulses from the card protocol engine, same clock
   typedef struct packed {
      logic       resp_end;
      logic       acc_end;
      logic [6:0] errors;
      logic       buf_rd;
      logic       buf_wr;
      logic       ill_access;
      logic       sdio_irq;
      logic       sdio_expub;
      logic       sdio_exwt;
   } engine_event_t;

   // the four request lines toward the system interrupt unit
   typedef struct packed {
      logic buffer_access_request;
      logic card_detect_request;
      logic card_access_request;
      logic sdio_access_request;
   } request_lines_t;
endpackage

// ===== logic/pin_sync.sv
// two-stage synchroniser for slow card pins with edge pulses
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] last_ff;

   // meta_ff feeds only sync_ff; edges compare the two later stages
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
         last_ff <= '0;
      end else if (ce) begin
         meta_ff <= pin;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise  = sync_ff & ~last_ff;
   assign fall  = ~sync_ff & last_ff;
endmodule

// ===== logic/sticky_flags.sv
// sticky event flags, write one to clear, set beats clear
module sticky_flags #(
   parameter int          W     = 32,
   parameter logic [W-1:0] WMASK = '1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] set,
   input  wire logic         clr_we,
   input  wire logic [W-1:0] clr_data,
   output logic      [W-1:0] q
);
   logic [W-1:0] flags_ff;
   wire  [W-1:0] clr_bits = clr_we ? (clr_data & WMASK) : '0;
   wire  [W-1:0] nxt_flags = (flags_ff & ~clr_bits) | (set & WMASK);

   // an event in the clearing cycle survives
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flags_ff <= '0;
      end else if (ce) begin
         flags_ff <= nxt_flags;
      end
   end

   assign q = flags_ff;
endmodule

// ===== logic/sd_irq_mask.sv
// sd host event flags, masks and request line generation
//
// The implementer's own choices: strobed register access and the register offsets.
module sd_irq_mask (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   input  wire logic [7:0]                 addr,
   input  wire logic [31:0]                wdata,
   input  wire logic                       wr_en,
   input  wire logic                       rd_en,
   output logic      [31:0]                rdata,
   input  wire sd_irq_pkg::engine_event_t  engine_event,
   input  wire logic                       cmd_busy,
   input  wire logic                       card_detect_pin,
   input  wire logic                       write_protect_pin,
   input  wire logic                       dat3_pin,
   input  wire logic                       dat0_pin,
   output sd_irq_pkg::request_lines_t      request_lines,
   output logic                            dtc_trigger,
   input  wire logic                       dtc_transfer_end,
   output logic                            irq
);
   logic [31:0] mask_pri_ff;
   logic [31:0] mask_sec_ff;
   logic [31:0] sdio_mask_ff;
   logic [4:0]  irq_mask_ff;
   logic [31:0] rdata_ff;
   logic [3:0]  lines_last_ff;
   logic [3:0]  pin_level;
   logic [3:0]  pin_rise;
   logic [3:0]  pin_fall;
   logic [31:0] stat_pri_q;
   logic [31:0] stat_sec_q;
   logic [31:0] sdio_q;
   logic [4:0]  irq_q;

   // register decode
   wire wr_stat_pri = wr_en && addr == sd_irq_pkg::OFS_STATUS_PRI;
   wire wr_stat_sec = wr_en && addr == sd_irq_pkg::OFS_STATUS_SEC;
   wire wr_mask_pri = wr_en && addr == sd_irq_pkg::OFS_MASK_PRI;
   wire wr_mask_sec = wr_en && addr == sd_irq_pkg::OFS_MASK_SEC;
   wire wr_sdio_st  = wr_en && addr == sd_irq_pkg::OFS_SDIO_STAT;
   wire wr_sdio_msk = wr_en && addr == sd_irq_pkg::OFS_SDIO_MASK;
   wire wr_irq_st   = wr_en && addr == sd_irq_pkg::OFS_IRQ_STAT;
   wire wr_irq_msk  = wr_en && addr == sd_irq_pkg::OFS_IRQ_MASK;

   // card pins come from outside and are synchronised first
   pin_sync #(
      .W (4)
   ) u_pins (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .pin     ({dat0_pin, dat3_pin, write_protect_pin, card_detect_pin}),
      .level   (pin_level),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   // primary event set terms; insertion is a rising presence level
   logic [31:0] set_pri;
   always_comb begin
      set_pri = '0;
      set_pri[sd_irq_pkg::BIT_RESP_END]  = engine_event.resp_end;
      set_pri[sd_irq_pkg::BIT_ACC_END]   = engine_event.acc_end;
      set_pri[sd_irq_pkg::BIT_CD_REMOVE] = pin_fall[0];
      set_pri[sd_irq_pkg::BIT_CD_INSERT] = pin_rise[0];
      set_pri[sd_irq_pkg::BIT_D3_REMOVE] = pin_fall[2];
      set_pri[sd_irq_pkg::BIT_D3_INSERT] = pin_rise[2];
   end

   // secondary event set terms
   logic [31:0] set_sec;
   always_comb begin
      set_sec = '0;
      set_sec[6:0]                         = engine_event.errors;
      set_sec[sd_irq_pkg::BIT_BUF_RD]     = engine_event.buf_rd;
      set_sec[sd_irq_pkg::BIT_BUF_WR]     = engine_event.buf_wr;
      set_sec[sd_irq_pkg::BIT_ILL_ACCESS] = engine_event.ill_access;
   end

   // sdio event set terms
   logic [31:0] set_sdio;
   always_comb begin
      set_sdio = '0;
      set_sdio[sd_irq_pkg::BIT_SDIO_IRQ]   = engine_event.sdio_irq;
      set_sdio[sd_irq_pkg::BIT_SDIO_EXPUB] = engine_event.sdio_expub;
      set_sdio[sd_irq_pkg::BIT_SDIO_EXWT]  = engine_event.sdio_exwt;
   end

   // flags record whether masked or not
   sticky_flags #(
      .W     (32),
      .WMASK (sd_irq_pkg::WR_PRI)
   ) u_stat_pri (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .set      (set_pri),
      .clr_we   (wr_stat_pri),
      .clr_data (wdata),
      .q        (stat_pri_q)
   );

   sticky_flags #(
      .W     (32),
      .WMASK (sd_irq_pkg::WR_SEC)
   ) u_stat_sec (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .set      (set_sec),
      .clr_we   (wr_stat_sec),
      .clr_data (wdata),
      .q        (stat_sec_q)
   );

   sticky_flags #(
      .W     (32),
      .WMASK (sd_irq_pkg::WR_SDIO)
   ) u_sdio (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .set      (set_sdio),
      .clr_we   (wr_sdio_st),
      .clr_data (wdata),
      .q        (sdio_q)
   );

   // mask registers keep only their writable bits
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mask_pri_ff  <= sd_irq_pkg::RST_MASK;
         mask_sec_ff  <= sd_irq_pkg::RST_MASK;
         sdio_mask_ff <= sd_irq_pkg::RST_MASK;
         irq_mask_ff  <= sd_irq_pkg::RST_IRQ_MASK;
      end else if (ce) begin
         if (wr_mask_pri) begin
            mask_pri_ff <= wdata & sd_irq_pkg::WR_PRI;
         end
         if (wr_mask_sec) begin
            mask_sec_ff <= wdata & sd_irq_pkg::WR_SEC;
         end
         if (wr_sdio_msk) begin
            sdio_mask_ff <= wdata & sd_irq_pkg::WR_SDIO;
         end
         if (wr_irq_msk) begin
            irq_mask_ff <= wdata[4:0];
         end
      end
   end

   // pending and permitted per group; a mask bit of one lets the event through
   wire [31:0] live_pri = stat_pri_q & mask_pri_ff;
   wire [31:0] live_sec = stat_sec_q & mask_sec_ff;
   wire [31:0] live_sdio = sdio_q & sdio_mask_ff;
   wire line_buf  = |(live_sec & sd_irq_pkg::BUF_SEC);
   wire line_det  = |(live_pri & sd_irq_pkg::DET_PRI);
   wire line_acc  = |(live_pri & sd_irq_pkg::ACC_PRI) |
                    |(live_sec & sd_irq_pkg::ACC_SEC);
   wire line_sdio = |live_sdio;
   wire [3:0] lines_now = {line_sdio, line_acc, line_det, line_buf};

   // four independent lines; the interrupt unit enables buffer alone and detect, access and sdio as one group
   assign request_lines.buffer_access_request = line_buf;
   assign request_lines.card_detect_request   = line_det;
   assign request_lines.card_access_request   = line_acc;
   assign request_lines.sdio_access_request   = line_sdio;
   assign dtc_trigger = line_buf;

   // local summary status: rising lines plus transfer end
   wire [4:0] irq_set = {dtc_transfer_end, lines_now & ~lines_last_ff};

   sticky_flags #(
      .W     (5),
      .WMASK (sd_irq_pkg::WR_IRQ)
   ) u_irq (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .set      (irq_set),
      .clr_we   (wr_irq_st),
      .clr_data (wdata[4:0]),
      .q        (irq_q)
   );

   assign irq = |(irq_q & irq_mask_ff);

   // read-only monitor bits show the synchronised pin levels; b14 shows the cmd_busy input directly
   logic [31:0] view_pri;
   logic [31:0] view_sec;
   always_comb begin
      view_pri = stat_pri_q;
      view_pri[sd_irq_pkg::BIT_CD_MON] = pin_level[0];
      view_pri[sd_irq_pkg::BIT_WP_MON] = pin_level[1];
      view_pri[sd_irq_pkg::BIT_D3_MON] = pin_level[2];
      view_sec = stat_sec_q;
      view_sec[sd_irq_pkg::BIT_D0_MON]   = pin_level[3];
      view_sec[sd_irq_pkg::BIT_CMD_BUSY] = cmd_busy;
   end

   // read select; unmapped addresses read zero
   wire [31:0] rd_sel =
      (addr == sd_irq_pkg::OFS_STATUS_PRI) ? view_pri :
      (addr == sd_irq_pkg::OFS_STATUS_SEC) ? view_sec :
      (addr == sd_irq_pkg::OFS_MASK_PRI)   ? mask_pri_ff :
      (addr == sd_irq_pkg::OFS_MASK_SEC)   ? mask_sec_ff :
      (addr == sd_irq_pkg::OFS_SDIO_STAT)  ? sdio_q :
      (addr == sd_irq_pkg::OFS_SDIO_MASK)  ? sdio_mask_ff :
      (addr == sd_irq_pkg::OFS_IRQ_STAT)   ? {27'h0000000, irq_q} :
      (addr == sd_irq_pkg::OFS_IRQ_MASK)   ? {27'h0000000, irq_mask_ff} :
      32'h0000_0000;

   // read data live only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_ff      <= sd_irq_pkg::RST_RDATA;
         lines_last_ff <= 4'h0;
      end else if (ce) begin
         rdata_ff      <= rd_en ? rd_sel : sd_irq_pkg::RST_RDATA;
         lines_last_ff <= lines_now;
      end
   end

   assign rdata = rdata_ff;
endmodule

// ===== testbench/sd_irq_mask_props.sv
// assertion checker on the ports of the sd host interrupt masking block
module sd_irq_mask_props (
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   input wire logic                       ce,
   input wire logic [7:0]                 addr,
   input wire logic [31:0]                wdata,
   input wire logic                       wr_en,
   input wire logic                       rd_en,
   input wire logic [31:0]                rdata,
   input wire sd_irq_pkg::engine_event_t  engine_event,
   input wire logic                       card_detect_pin,
   input wire sd_irq_pkg::request_lines_t request_lines,
   input wire logic                       dtc_trigger
);
   logic [31:0] mask_pri_ff;
   logic [31:0] mask_sec_ff;
   logic [31:0] mask_sdio_ff;
   // decoded mask writes, so line checks know what software allowed
   wire logic wr_pri  = ce && wr_en && addr == sd_irq_pkg::OFS_MASK_PRI;
   wire logic wr_sec  = ce && wr_en && addr == sd_irq_pkg::OFS_MASK_SEC;
   wire logic wr_sdio = ce && wr_en && addr == sd_irq_pkg::OFS_SDIO_MASK;
   // shadow masks keep only writable bits, as the design should
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mask_pri_ff  <= '0;
         mask_sec_ff  <= '0;
         mask_sdio_ff <= '0;
      end else begin
         if (wr_pri) mask_pri_ff <= wdata & sd_irq_pkg::WR_PRI;
         if (wr_sec) mask_sec_ff <= wdata & sd_irq_pkg::WR_SEC;
         if (wr_sdio) mask_sdio_ff <= wdata & sd_irq_pkg::WR_SDIO;
      end
   end
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // write then read of the same place with no gap
   sequence s_wr_rd(w, a);
      w ##1 (ce && rd_en && addr == a);
   endsequence
   property p_mask_pri;
      s_wr_rd(wr_pri, sd_irq_pkg::OFS_MASK_PRI) |=>
         rdata == ($past(wdata, 2) & sd_irq_pkg::WR_PRI);
   endproperty
   property p_mask_sec;
      s_wr_rd(wr_sec, sd_irq_pkg::OFS_MASK_SEC) |=>
         rdata == ($past(wdata, 2) & sd_irq_pkg::WR_SEC);
   endproperty
   property p_acc_line;
      ce && engine_event.errors[0] && mask_sec_ff[0] && !wr_sec |=>
         request_lines.card_access_request;
   endproperty
   property p_buf_line;
      ce && engine_event.buf_rd && mask_sec_ff[sd_irq_pkg::BIT_BUF_RD] && !wr_sec |=>
         request_lines.buffer_access_request;
   endproperty
   property p_sdio_line;
      ce && engine_event.sdio_irq && mask_sdio_ff[0] && !wr_sdio |=>
         request_lines.sdio_access_request;
   endproperty
   property p_det_line;
      $rose(card_detect_pin) && mask_pri_ff[sd_irq_pkg::BIT_CD_INSERT] |->
         ##[1:6] request_lines.card_detect_request;
   endproperty
   property p_acc_hold;
      $fell(request_lines.card_access_request) |-> $past(wr_en);
   endproperty
   property p_buf_masked;
      (mask_sec_ff & sd_irq_pkg::BUF_SEC) == '0 |-> !request_lines.buffer_access_request;
   endproperty
   property p_dtc;
      ce && engine_event.buf_wr && mask_sec_ff[sd_irq_pkg::BIT_BUF_WR] && !wr_sec |=>
         dtc_trigger;
   endproperty
   a_mask_pri: assert property (p_mask_pri) else $error("primary mask readback wrong");
   a_mask_sec: assert property (p_mask_sec) else $error("secondary mask readback wrong");
   a_acc_line: assert property (p_acc_line) else $error("access line missing");
   a_buf_line: assert property (p_buf_line) else $error("buffer line missing");
   a_sdio_line: assert property (p_sdio_line) else $error("sdio line missing");
   a_det_line: assert property (p_det_line) else $error("detect line missing");
   a_acc_hold: assert property (p_acc_hold) else $error("access line dropped alone");
   a_buf_masked: assert property (p_buf_masked) else $error("masked buffer line");
   a_dtc: assert property (p_dtc) else $error("buffer write gave no transfer trigger");
endmodule

bind sd_irq_mask sd_irq_mask_props u_sd_irq_mask_props (.clk_sys, .rst_n, .ce, .addr, .wdata,
   .wr_en, .rd_en, .rdata, .engine_event, .card_detect_pin, .request_lines, .dtc_trigger);

// ===== testbench/sys_irq_model.sv
// behavioural model of the system interrupt unit and the transfer controller
module sys_irq_model #(
   parameter int         XFER_CYCLES = 6,
   parameter logic [3:0] LEVEL       = 4'h5
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire sd_irq_pkg::request_lines_t request_lines,
   input  wire logic                       dtc_trigger,
   output logic                            dtc_transfer_end,
   output logic                            cpu_req
);
   logic [1:0] request_enable_bit = 2'h0;   // b0 three-line group, b1 buffer line
   logic [3:0] grp_priority_field = 4'h0;
   logic [3:0] buf_priority_field = 4'h0;
   logic       trig_q             = 1'b0;
   int         cnt                = 0;
   // one select value covers detect, access and sdio; switching off zeroes the level
   task automatic set_lines(input logic [15:0] sel, input logic on);
      if (sel[0]) begin
         request_enable_bit[0] = on;
         grp_priority_field    = on ? LEVEL : 4'h0;
      end
      if (sel[4]) begin
         request_enable_bit[1] = on;
         buf_priority_field    = on ? LEVEL : 4'h0;
      end
   endtask
   // a line reaches the processor only when enabled here with a nonzero level
   assign cpu_req = (request_enable_bit[0] && grp_priority_field != 4'h0 &&
                     (request_lines.card_detect_request || request_lines.card_access_request ||
                      request_lines.sdio_access_request)) ||
                    (request_enable_bit[1] && buf_priority_field != 4'h0 &&
                     request_lines.buffer_access_request);
   // a rising trigger with the buffer line enabled and no transfer running starts a slow transfer, ended by a one-cycle pulse
   always @(posedge clk_sys) begin
      trig_q <= dtc_trigger;
      dtc_transfer_end <= 1'b0;
      if (!rst_n) begin
         cnt <= 0;
      end else if (cnt == 1) begin
         cnt <= 0;
         dtc_transfer_end <= 1'b1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (dtc_trigger && !trig_q && request_enable_bit[1]) begin
         cnt <= XFER_CYCLES;
      end
   end
endmodule

// ===== testbench/test_sd_irq_mask.sv
// self-checking bench for the sd host interrupt masking block
module test_sd_irq_mask;
   timeunit 1ns;
   timeprecision 1ns;
   logic                       clk_sys, rst_n, ce, wr_en, rd_en, cd_pin, dtc_end, irq, cpu_req;
   logic [7:0]                 addr;
   logic [31:0]                wdata, rdata;
   sd_irq_pkg::engine_event_t  engine_event, ev;
   sd_irq_pkg::request_lines_t request_lines;
   logic                       dtc_trigger;
   int                         n_fail = 0;
   int                         n_tests = 0;
   int                         b;
   sd_irq_mask u_sd_irq_mask (.clk_sys, .rst_n, .ce, .addr, .wdata, .wr_en, .rd_en, .rdata,
      .engine_event, .cmd_busy(1'b0), .card_detect_pin(cd_pin), .write_protect_pin(1'b0),
      .dat3_pin(1'b0), .dat0_pin(1'b0), .request_lines, .dtc_trigger,
      .dtc_transfer_end(dtc_end), .irq);
   sys_irq_model u_sys_irq_model (.clk_sys, .rst_n, .request_lines, .dtc_trigger,
      .dtc_transfer_end(dtc_end), .cpu_req);
   always #50 clk_sys = ~clk_sys;
   task automatic complete_run;
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   // read lands one cycle after the strobe and only there
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask
   // write then read back with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      wr(a, d);
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 chk("mask_readback", e, rdata);
   endtask
   task automatic pulse(input sd_irq_pkg::engine_event_t e);
      @(posedge clk_sys);
      engine_event <= e;
      @(posedge clk_sys);
      engine_event <= '0;
      #1;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      complete_run;
   end
   initial begin
      {clk_sys, rst_n, wr_en, rd_en, cd_pin} = '0;
      // one by one: a packed concatenation would pad by width and leave ce low
      ce = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      engine_event = '0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk("mask_pri_reset", sd_irq_pkg::OFS_MASK_PRI, sd_irq_pkg::RST_MASK);
      rd_chk("mask_sec_reset", sd_irq_pkg::OFS_MASK_SEC, sd_irq_pkg::RST_MASK);
      wr(8'h40, 32'hffff_ffff);
      rd_chk("unmapped", 8'h40, 32'h0);
      wr_rd(sd_irq_pkg::OFS_MASK_PRI, 32'hffff_ffff, 32'h0000_031d);
      wr_rd(sd_irq_pkg::OFS_MASK_SEC, 32'hffff_ffff, 32'h0000_837f);
      wr_rd(sd_irq_pkg::OFS_MASK_PRI, 32'h0, 32'h0);
      // every access-group error bit: flag, line, write-zero keeps, write-one clears
      for (int k = 0; k < 8; k++) begin
         b = (k < 7) ? k : 15;
         ev = '0;
         if (k < 7) ev.errors[k] = 1'b1;
         else ev.ill_access = 1'b1;
         wr(sd_irq_pkg::OFS_MASK_SEC, 32'h1 << b);
         pulse(ev);
         chk("acc_line", 32'h1, 32'(request_lines.card_access_request));
         wr(sd_irq_pkg::OFS_STATUS_SEC, 32'h0);
         rd_chk("stat_sec_keep", sd_irq_pkg::OFS_STATUS_SEC, 32'h1 << b);
         wr(sd_irq_pkg::OFS_STATUS_SEC, 32'h1 << b);
         #1 chk("acc_line_clr", 32'h0, 32'(request_lines.card_access_request));
      end
      // masked event latches its flag, line shows once the mask opens
      wr(sd_irq_pkg::OFS_MASK_SEC, 32'h0);
      ev = '0;
      ev.errors[3] = 1'b1;
      pulse(ev);
      chk("acc_masked", 32'h0, 32'(request_lines.card_access_request));
      rd_chk("stat_masked", sd_irq_pkg::OFS_STATUS_SEC, 32'h8);
      wr(sd_irq_pkg::OFS_MASK_SEC, 32'h8);
      #1 chk("cpu_off", 32'h0, 32'(cpu_req));
      u_sys_irq_model.set_lines(16'h0001, 1'b1);
      #1 chk("cpu_on", 32'h1, 32'(cpu_req));
      chk("irq_masked", 32'h0, 32'(irq));
      wr(sd_irq_pkg::OFS_IRQ_MASK, 32'h4);
      #1 chk("irq_on", 32'h1, 32'(irq));
      wr(sd_irq_pkg::OFS_IRQ_STAT, 32'h4);
      #1 chk("irq_clr", 32'h0, 32'(irq));
      u_sys_irq_model.set_lines(16'h0001, 1'b0);
      #1 chk("cpu_dis", 32'h0, 32'(cpu_req));
      wr(sd_irq_pkg::OFS_STATUS_SEC, 32'h8);
      // buffer line starts a transfer whose end lands in summary status
      u_sys_irq_model.set_lines(16'h0010, 1'b1);
      wr(sd_irq_pkg::OFS_MASK_SEC, 32'h300);
      ev = '0;
      ev.buf_rd = 1'b1;
      pulse(ev);
      chk("buf_trig", 32'h1, 32'(dtc_trigger));
      for (int i = 0; i < 20 && dtc_end !== 1'b1; i++) #100;
      chk("xfer_end", 32'h1, 32'(dtc_end));
      rd_chk("xfer_stat", sd_irq_pkg::OFS_IRQ_STAT, 32'h11);
      wr(sd_irq_pkg::OFS_STATUS_SEC, 32'h100);
      #1 chk("buf_clr", 32'h0, 32'(dtc_trigger));
      ev = '0;
      ev.buf_wr = 1'b1;
      pulse(ev);
      chk("buf_wr_line", 32'h1, 32'(request_lines.buffer_access_request));
      // card insertion through the pin synchroniser
      wr(sd_irq_pkg::OFS_MASK_PRI, 32'h10);
      cd_pin <= 1'b1;
      // poll off the clock edge so the line is seen settled
      #1;
      for (int i = 0; i < 8 && request_lines.card_detect_request !== 1'b1; i++) #100;
      chk("det_line", 32'h1, 32'(request_lines.card_detect_request));
      rd_chk("stat_pri", sd_irq_pkg::OFS_STATUS_PRI, 32'h30);
      wr(sd_irq_pkg::OFS_SDIO_MASK, 32'h1);
      ev = '0;
      ev.sdio_irq = 1'b1;
      pulse(ev);
      chk("sdio_line", 32'h1, 32'(request_lines.sdio_access_request));
      rd_chk("sdio_stat", sd_irq_pkg::OFS_SDIO_STAT, 32'h1);
      // clock enable low freezes the flags, so a pulse then is lost
      ce <= 1'b0;
      ev = '0;
      ev.resp_end = 1'b1;
      pulse(ev);
      ce <= 1'b1;
      rd_chk("ce_frozen", sd_irq_pkg::OFS_STATUS_PRI, 32'h30);
      // reset in mid-run drops every line and mask
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      #1 chk("lines_rst", 32'h0, 32'(request_lines));
      rd_chk("mask_rst", sd_irq_pkg::OFS_MASK_PRI, 32'h0);
      complete_run;
   end
endmodule
